// [include/dioc_consts.vh]
/*
 * shared constants of the digital i/o channel path block: register
 * addresses, field positions, path codes and reset values.
 * assumes it is included by bare name from the rtl files.
 */
`ifndef DIOC_CONSTS_VH
`define DIOC_CONSTS_VH

// register addresses on the plain software port
`define DIOC_ADDR_W 32
`define DIOC_ADDR_RUN_CTRL 32'h1000_0002
`define DIOC_ADDR_IN_MON 32'h1000_3100
`define DIOC_ADDR_OUT_MON 32'h1000_4020
`define DIOC_ADDR_COMMIT 32'h1000_a000
// staged path control: base + slot*16 + channel, one register each
`define DIOC_ADDR_PATH_BASE 32'h1000_c000
`define DIOC_ADDR_PATH_MASK 32'hffff_ff80
// extra monitor block for all slots: base + slot*2 (+1 for outputs)
`define DIOC_ADDR_MON_BASE 32'h1000_c100
`define DIOC_ADDR_MON_MASK 32'hffff_fff0

// field positions
`define DIOC_RUN_BIT 0
`define DIOC_COMMIT_BIT 0

// path control codes
`define DIOC_CODE_W 16
`define DIOC_CODE_ZERO 16'h0000
`define DIOC_CODE_PASS 16'h0001
`define DIOC_CODE_INV 16'h0003

// reset values
`define DIOC_RST_CODE 16'h0000
`define DIOC_RST_RUN 1'b0
`define DIOC_DATA_W 16
`define DIOC_RD_ZERO 16'h0000

`endif

// [rtl/dioc_channel_slot.v]
/*
 * one board slot: sixteen channels, each routing input n to output n
 * through its own committed path control code.
 * assumes inputs are already synchronised and codes come from registers.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dioc_consts.vh"

module dioc_channel_slot #(
   parameter CHANNELS = 16
) (
   input wire mclk,
   input wire sys_rst,
   input wire [CHANNELS-1:0] in_level,
   input wire [CHANNELS*`DIOC_CODE_W-1:0] path_code,
   output wire [CHANNELS-1:0] out_level
);

   // decode one channel; unknown codes fall back to a held-low output
   function path_out;
      input [`DIOC_CODE_W-1:0] code;
      input lvl;
      begin
         case (code)
            `DIOC_CODE_ZERO: path_out = 1'b0;
            `DIOC_CODE_PASS: path_out = lvl;
            `DIOC_CODE_INV: path_out = ~lvl;
            default: path_out = 1'b0;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // per-channel output flops, registered so pins never glitch
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_ch
         reg out_ff;
         wire nxt_out;
         assign nxt_out = path_out(path_code[ch*`DIOC_CODE_W +: `DIOC_CODE_W], in_level[ch]);
         always @(posedge mclk) begin
            if (sys_rst) begin
               out_ff <= 1'b0;
            end else begin
               out_ff <= nxt_out;
            end
         end
         assign out_level[ch] = out_ff;
      end
   endgenerate

endmodule // dioc_channel_slot
`default_nettype wire

// [rtl/dioc_path_top.v]
/*
 * digital i/o channel path control: six board slots of sixteen
 * channels, staged path codes applied on a commit write, run control
 * driving the active-low board resets, and level monitors.
 * assumes a single 125 MHz clock, a synchronous active-high reset and
 * asynchronous input pins, which are synchronised here.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dioc_consts.vh"

// Functional notes
// - writing run bit 0 as 0 drives both board resets low
// - writing run bit 0 as 1 releases both board resets high
// - staged path codes take effect only after a commit register write
// - path code 0000h holds the output at zero
// - path code 0001h copies input level to output
// - path code 0003h drives the inverted input level
// - sixteen independent channels per slot, input n to output n
// - six slots: three of the first group, three of the second
// - slot b0 input and output levels readable, bit 0 is channel 0
module dioc_path_top #(
   parameter CHANNELS = 16,
   parameter SLOTS = 6
) (
   input wire mclk,
   input wire sys_rst,
   input wire [`DIOC_ADDR_W-1:0] reg_addr,
   input wire [`DIOC_DATA_W-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output wire [`DIOC_DATA_W-1:0] reg_rdata,
   input wire [SLOTS*CHANNELS-1:0] slot_input,
   output wire [SLOTS*CHANNELS-1:0] slot_output,
   output wire first_group_board_reset_n,
   output wire second_group_board_reset_n
);

   localparam CODES = SLOTS * CHANNELS;
   localparam CW = `DIOC_CODE_W;

   ////////////////////////////////////////////////////////////////////
   // address decode helpers
   function is_path_addr;
      input [`DIOC_ADDR_W-1:0] a;
      begin
         is_path_addr = ((a & `DIOC_ADDR_PATH_MASK) == `DIOC_ADDR_PATH_BASE) &&
                        (a[6:0] < CODES);
      end
   endfunction

   function is_mon_addr;
      input [`DIOC_ADDR_W-1:0] a;
      begin
         is_mon_addr = ((a & `DIOC_ADDR_MON_MASK) == `DIOC_ADDR_MON_BASE) &&
                       (a[3:0] < 2 * SLOTS);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // pin synchroniser: three stages, change taken when last two agree
   reg [CODES-1:0] sync1_ff;
   reg [CODES-1:0] sync2_ff;
   reg [CODES-1:0] sync3_ff;
   reg [CODES-1:0] in_lvl_ff;
   wire [CODES-1:0] nxt_in_lvl;

   // stage one feeds only stage two, so metastability stays contained
   always @(posedge mclk) begin
      if (sys_rst) begin
         sync1_ff <= {CODES{1'b0}};
         sync2_ff <= {CODES{1'b0}};
         sync3_ff <= {CODES{1'b0}};
         in_lvl_ff <= {CODES{1'b0}};
      end else begin
         sync1_ff <= slot_input;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         in_lvl_ff <= nxt_in_lvl;
      end
   end

   // a bit moves only once stages two and three agree
   assign nxt_in_lvl = (sync2_ff & sync3_ff) | (in_lvl_ff & (sync2_ff | sync3_ff));

   ////////////////////////////////////////////////////////////////////
   // staged and committed path codes
   reg [CODES*CW-1:0] staged_ff;
   reg [CODES*CW-1:0] active_ff;
   reg commit_ff;
   reg run_ff;
   wire wr_path;
   wire wr_commit;
   wire wr_run;
   wire [6:0] path_idx;

   assign wr_path = reg_wr && is_path_addr(reg_addr);
   assign wr_commit = reg_wr && (reg_addr == `DIOC_ADDR_COMMIT);
   assign wr_run = reg_wr && (reg_addr == `DIOC_ADDR_RUN_CTRL);
   assign path_idx = reg_addr[6:0];

   genvar gi;
   generate
      for (gi = 0; gi < CODES; gi = gi + 1) begin : g_stage
         // staged write only lands in the shadow copy
         always @(posedge mclk) begin
            if (sys_rst) begin
               staged_ff[gi*CW +: CW] <= `DIOC_RST_CODE;
            end else if (wr_path && (path_idx == gi)) begin
               staged_ff[gi*CW +: CW] <= reg_wdata;
            end
         end
      end
   endgenerate

   // commit copies every shadow at once, so channels switch together
   always @(posedge mclk) begin
      if (sys_rst) begin
         active_ff <= {CODES{`DIOC_RST_CODE}};
      end else if (wr_commit) begin
         active_ff <= staged_ff;
      end
   end

   // commit register keeps its last written value for readback
   always @(posedge mclk) begin
      if (sys_rst) begin
         commit_ff <= 1'b0;
      end else if (wr_commit) begin
         commit_ff <= reg_wdata[`DIOC_COMMIT_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // run control: boards held in reset until software starts
   always @(posedge mclk) begin
      if (sys_rst) begin
         run_ff <= `DIOC_RST_RUN;
      end else if (wr_run) begin
         run_ff <= reg_wdata[`DIOC_RUN_BIT];
      end
   end

   assign first_group_board_reset_n = run_ff;
   assign second_group_board_reset_n = run_ff;

   ////////////////////////////////////////////////////////////////////
   // slot instances: b0..b2 then e0..e2 in the packed vectors
   genvar gs;
   generate
      for (gs = 0; gs < SLOTS; gs = gs + 1) begin : g_slot
         dioc_channel_slot #(
            .CHANNELS(CHANNELS)
         ) u_slot (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .in_level(in_lvl_ff[gs*CHANNELS +: CHANNELS]),
            .path_code(active_ff[gs*CHANNELS*CW +: CHANNELS*CW]),
            .out_level(slot_output[gs*CHANNELS +: CHANNELS])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // read path: data stands in the cycle after the strobe only
   reg [`DIOC_DATA_W-1:0] rdata_ff;
   reg [`DIOC_DATA_W-1:0] nxt_rdata;
   wire [3:0] mon_idx;
   wire [2:0] mon_slot;

   assign mon_idx = reg_addr[3:0];
   assign mon_slot = mon_idx[3:1];

   // unmapped addresses read as zero rather than stalling the master
   always @* begin
      nxt_rdata = `DIOC_RD_ZERO;
      if (reg_rd) begin
         if (reg_addr == `DIOC_ADDR_RUN_CTRL) begin
            nxt_rdata[`DIOC_RUN_BIT] = run_ff;
         end else if (reg_addr == `DIOC_ADDR_COMMIT) begin
            nxt_rdata[`DIOC_COMMIT_BIT] = commit_ff;
         end else if (reg_addr == `DIOC_ADDR_IN_MON) begin
            nxt_rdata = in_lvl_ff[CHANNELS-1:0];
         end else if (reg_addr == `DIOC_ADDR_OUT_MON) begin
            nxt_rdata = slot_output[CHANNELS-1:0];
         end else if (is_path_addr(reg_addr)) begin
            nxt_rdata = staged_ff[path_idx*CW +: CW];
         end else if (is_mon_addr(reg_addr)) begin
            if (mon_idx[0]) begin
               nxt_rdata = slot_output[mon_slot*CHANNELS +: CHANNELS];
            end else begin
               nxt_rdata = in_lvl_ff[mon_slot*CHANNELS +: CHANNELS];
            end
         end
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         rdata_ff <= `DIOC_RD_ZERO;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

endmodule // dioc_path_top
`default_nettype wire

// [verification/dioc_path_asserts.sv]
/* port checker for dioc_path_top: board resets, monitors, read port.
   assumes one mclk domain with synchronous active-high sys_rst. */
`timescale 1ns/10ps
`default_nettype none
`include "dioc_consts.vh"
module dioc_path_asserts #(
   parameter CHANNELS = 16,
   parameter SLOTS = 6
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [`DIOC_ADDR_W-1:0] reg_addr,
   input wire logic [`DIOC_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [`DIOC_DATA_W-1:0] reg_rdata,
   input wire logic [SLOTS*CHANNELS-1:0] slot_input,
   input wire logic [SLOTS*CHANNELS-1:0] slot_output,
   input wire logic first_group_board_reset_n,
   input wire logic second_group_board_reset_n
);
   wire logic run_wr = reg_wr && reg_addr == `DIOC_ADDR_RUN_CTRL;
   logic committed_ff;
   logic nxt_committed;
   // outputs may only leave zero once some commit has landed
   always_comb nxt_committed = committed_ff | (reg_wr && reg_addr == `DIOC_ADDR_COMMIT);
   always_ff @(posedge mclk) begin
      if (sys_rst) committed_ff <= 1'b0;
      else committed_ff <= nxt_committed;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   chk_rst_low: assert property (
      run_wr && !reg_wdata[`DIOC_RUN_BIT] |-> ##[1:2] !first_group_board_reset_n && !second_group_board_reset_n)
      else $error("board resets not low after stop");
   chk_rst_high: assert property (
      run_wr && reg_wdata[`DIOC_RUN_BIT] |-> ##[1:2] first_group_board_reset_n && second_group_board_reset_n)
      else $error("board resets not released after start");
   chk_rst_pair: assert property (first_group_board_reset_n == second_group_board_reset_n)
      else $error("board resets differ");
   chk_rst_hold: assert property (!run_wr [*2] |=> $stable(first_group_board_reset_n))
      else $error("board reset moved without a run write");
   chk_zero_idle: assert property (!committed_ff |-> slot_output == {SLOTS*CHANNELS{1'b0}})
      else $error("output moved before any commit");
   chk_out_mon: assert property (
      reg_rd && reg_addr == `DIOC_ADDR_OUT_MON |=> reg_rdata == $past(slot_output[15:0]))
      else $error("output monitor mismatch");
   chk_in_mon: assert property (
      $stable(slot_input[15:0]) [*6] ##0 (reg_rd && reg_addr == `DIOC_ADDR_IN_MON)
      |=> reg_rdata == $past(slot_input[15:0]))
      else $error("input monitor mismatch");
   chk_rd_quiet: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data without a read");
endmodule // dioc_path_asserts
////////////////////////////////////////
bind dioc_path_top dioc_path_asserts #(.CHANNELS(CHANNELS), .SLOTS(SLOTS)) chk_u (.mclk(mclk),
   .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .slot_input(slot_input), .slot_output(slot_output),
   .first_group_board_reset_n(first_group_board_reset_n),
   .second_group_board_reset_n(second_group_board_reset_n));
`default_nettype wire

// [verification/dioc_board_model.sv]
/* dc board group model: drives the input pins of its slots.
   assumes the mclk domain and an active-low board reset. */
`timescale 1ns/10ps
`default_nettype none
module dioc_board_model #(
   parameter W = 48
) (
   input wire logic mclk,
   input wire logic board_reset_n,
   input wire logic [W-1:0] pattern,
   output logic [W-1:0] pins
);
   // a board held in reset drives nothing, so inputs read low
   always_ff @(posedge mclk) begin
      pins <= board_reset_n ? pattern : {W{1'b0}};
   end
endmodule // dioc_board_model
`default_nettype wire

// [verification/tb.sv]
/* self-checking bench for dioc_path_top: reset, run-start and staging cases, then
   a table of path codes, then monitor and run-stop cases. assumes nothing else. */
`timescale 1ns/10ps
`default_nettype none
`include "dioc_consts.vh"
module tb;
   typedef struct {int ch; logic [15:0] code; logic pin; logic exp;} dioc_row_t;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [31:0] reg_addr = 32'h0;
   logic [15:0] reg_wdata = 16'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [95:0] pattern = 96'h0;
   logic [15:0] d;
   logic [15:0] codes [96] = '{default: 16'h0};
   wire logic [15:0] reg_rdata;
   wire logic [95:0] slot_input;
   wire logic [95:0] slot_output;
   wire logic rst_a_n;
   wire logic rst_b_n;
   int failures = 0;
   int checks_done = 0;
   // odd codes 0005h and ffffh must read as forced zero
   dioc_row_t rows [8] = '{'{0, 16'h0001, 1, 1}, '{0, 16'h0003, 1, 0}, '{17, 16'h0003, 0, 1},
      '{40, 16'h0001, 0, 0}, '{63, 16'h0000, 1, 0}, '{79, 16'h0005, 1, 0}, '{95, 16'hffff, 1, 0},
      '{95, 16'h0003, 0, 1}};
   always #4 mclk = ~mclk;
   dioc_path_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slot_input(slot_input),
      .slot_output(slot_output), .first_group_board_reset_n(rst_a_n), .second_group_board_reset_n(rst_b_n));
   dioc_board_model board_b_u (.mclk(mclk), .board_reset_n(rst_a_n), .pattern(pattern[47:0]),
      .pins(slot_input[47:0]));
   dioc_board_model board_e_u (.mclk(mclk), .board_reset_n(rst_b_n), .pattern(pattern[95:48]),
      .pins(slot_input[95:48]));
   ////////////////////////////////////////
   task automatic wr(input logic [31:0] a, input logic [15:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, output logic [15:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // wide enough for both board resets beside all 96 output pins
   task automatic check(input logic [97:0] got, input logic [97:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // expected pins from the codes the bench has committed
   function automatic logic [95:0] model_out();
      logic [95:0] o;
      for (int i = 0; i < 96; i++)
         o[i] = codes[i] == 16'h0001 ? pattern[i] : (codes[i] == 16'h0003 ? !pattern[i] : 1'b0);
      return o;
   endfunction
   task automatic final_report();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   // main sequence
   initial begin
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      tick(1);
      check({rst_a_n, rst_b_n, slot_output}, 98'h0);
      wr(`DIOC_ADDR_RUN_CTRL, 16'h0001);
      pattern <= {96{1'b1}};
      tick(2);
      check({rst_a_n, rst_b_n}, 2'b11);
      wr(`DIOC_ADDR_PATH_BASE + 5, 16'h0001);
      tick(10);
      check(slot_output, 96'h0);
      wr(`DIOC_ADDR_COMMIT, 16'h0001);
      codes[5] = 16'h0001;
      tick(3);
      check(slot_output, 96'h20);
      foreach (rows[i]) begin
         wr(`DIOC_ADDR_PATH_BASE + rows[i].ch, rows[i].code);
         pattern <= {96{rows[i].pin}} ^ ({6{16'h5aa5}} & ~(96'h1 << rows[i].ch));
         wr(`DIOC_ADDR_COMMIT, 16'h0001);
         codes[rows[i].ch] = rows[i].code;
         tick(10);
         check(slot_output[rows[i].ch], rows[i].exp);
         check(slot_output, model_out());
      end
      rd(`DIOC_ADDR_IN_MON, d);
      check(d, pattern[15:0]);
      rd(`DIOC_ADDR_OUT_MON, d);
      check(d, model_out() & 96'hffff);
      rd(`DIOC_ADDR_PATH_BASE + 5, d);
      check(d, 16'h0001);
      rd(32'h1000_0004, d);
      check(d, 16'h0);
      wr(`DIOC_ADDR_RUN_CTRL, 16'h0000);
      tick(2);
      check({rst_a_n, rst_b_n}, 2'b00);
      final_report();
   end
   // watchdog, far beyond the 150 or so cycles the run needs
   initial begin
      #(8 * 5000);
      failures++;
      final_report();
   end
endmodule // tb
`default_nettype wire
